// ---- src/fudh_pkg.sv ----
// Constants and types shared by the underflow and divide-by-zero exception unit.
package fudh_pkg;

    localparam int EXP_W = 17;
    localparam int MANT_W = 64;
    localparam int SEXP_W = 15;

    // Exponent biases and limits on an 18-bit signed scale; the field values are 15 bits.
    localparam logic [17:0] BIAS_EXT = 18'h03fff;
    localparam logic [17:0] BIAS_WRAP = 18'h06000;
    localparam logic [17:0] EMIN_EXT = 18'h3c001;
    localparam logic [17:0] EMIN_DBL = 18'h3fc02;
    localparam logic [17:0] EMIN_SGL = 18'h3ff82;
    localparam logic [17:0] CATA_LIMIT = 18'h36001;
    localparam logic [17:0] SHIFT_MAX = 18'h0007f;
    localparam logic [14:0] EXP_INF = 15'h7fff;
    localparam logic [14:0] EXP_ZERO = 15'h0000;

    // Position of the last kept mantissa bit for each precision.
    localparam logic [5:0] LSB_EXT = 6'h00;
    localparam logic [5:0] LSB_DBL = 6'h0b;
    localparam logic [5:0] LSB_SGL = 6'h28;

    localparam logic [31:0] ADDR_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        OP_OTHER = 4'h0,
        OP_FULL_DIV = 4'h1,
        OP_SGL_DIV = 4'h2,
        OP_SGL_MUL = 4'h3,
        OP_LOG_TEN = 4'h4,
        OP_LOG_TWO = 4'h5,
        OP_LOG_NAT = 4'h6,
        OP_LOG_ONE_PLUS = 4'h7,
        OP_ATANH = 4'h8,
        OP_EXPONENTIAL = 4'h9
    } fudh_op_t;

    typedef enum logic [1:0] {
        PREC_EXT = 2'h0,
        PREC_SGL = 2'h1,
        PREC_DBL = 2'h2
    } fudh_prec_t;

    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_TOWARD_ZERO = 2'h1,
        RND_TOWARD_MINUS = 2'h2,
        RND_TOWARD_PLUS = 2'h3
    } fudh_rnd_t;

    typedef enum logic [1:0] {
        PRIM_NONE = 2'h0,
        PRIM_PRE = 2'h1,
        PRIM_MID = 2'h2
    } fudh_prim_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PEND = 2'b10
    } fudh_state_t;

endpackage

// ---- src/fudh_unit.sv ----
// Underflow and divide-by-zero exception unit of the floating-point coprocessor.
// Functional notes
// RQ1 - Register destination, single or double: round mantissa and exponent range to precision.
// RQ2 - Single-mantissa multiply and divide keep extended exponent range, single mantissa.
// RQ3 - Intermediate is normalized 17-bit exponent; untrapped tiny result is denormal or zero.
// RQ4 - Denormalize by right shift up to the format minimum exponent, then round.
// RQ5 - When all bits shift out, rounding mode picks signed zero or smallest denormal.
// RQ6 - Exponent equal to extended minimum is not tiny.
// RQ7 - Trapped underflow to memory or host register: store result, then take mid-instruction.
// RQ8 - Trapped exception to a register: take primitive on next response register read.
// RQ9 - Non-concurrent variant reports pre-instruction; concurrent variant reports mid-instruction.
// RQ10 - On underflow keep faulting address and exceptional operand for state frame save.
// RQ11 - Memory destination operand: rounded to destination precision, normal 15-bit bias.
// RQ12 - Register destination operand: extended rounding, bias 3fff plus 6000, wrapped.
// RQ13 - Exponential operation at or below 16001 gives exceptional exponent zero.
// RQ14 - Sticky tiny flag needs tininess and accuracy loss.
// RQ15 - Trap-cause tiny flag set on tininess alone.
// RQ16 - Divide-by-zero for zero divisors, logs of zero, log1p of -1, atanh of one.
// RQ17 - Divide-by-zero sets the zero divide flag.
// RQ18 - Untrapped divide-by-zero results: signed infinity per operation.
// RQ19 - Trapped divide-by-zero leaves destination unchanged and takes on response read.
// RQ20 - Divide-by-zero keeps faulting address; operand is source in extended form.
// RQ21 - Underflow is checked, then rounding done, before the result is stored.
// RQ22 - Trap-cause flags and operand hold until response read or state frame save.
`timescale 1ns/10ps

module fudh_unit #(
    parameter int ADDR_W = 32,
    parameter bit CONCURRENT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic dest_is_reg,
    input wire logic [1:0] rnd_prec,
    input wire logic [1:0] rnd_mode,
    input wire logic int_sign,
    input wire logic [16:0] int_exp,
    input wire logic [63:0] int_mant,
    input wire logic int_sticky,
    input wire logic src_sign,
    input wire logic [14:0] src_exp,
    input wire logic [63:0] src_mant,
    input wire logic src_is_zero,
    input wire logic src_is_one,
    input wire logic dvd_sign,
    input wire logic dvd_special,
    input wire logic tiny_result_flag_trap_en,
    input wire logic dz_trap_en,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic resp_read,
    input wire logic frame_save,
    input wire logic sticky_clear,
    output logic op_ready,
    output logic res_valid,
    output logic res_write,
    output logic res_sign,
    output logic [14:0] res_exp,
    output logic [63:0] res_mant,
    output logic trap_tiny_result_flag,
    output logic trap_zero_divide_flag,
    output logic sticky_tiny_result_flag,
    output logic sticky_zero_divide_flag,
    output logic [ADDR_W-1:0] faulting_instruction_address,
    output logic take_mid,
    output logic resp_valid,
    output logic [1:0] resp_prim,
    output logic frame_valid,
    output logic eo_sign,
    output logic [14:0] eo_exp,
    output logic [63:0] eo_mant
);

    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
        $error("fudh_unit: ADDR_W must lie between 1 and 32");
    end

    // Shift, round and report: {all_gone, inexact, carry, mantissa}.
    function automatic logic [66:0] rnd_fn(input logic [63:0] m, input logic stk,
                                           input logic [6:0] sh, input logic [5:0] lsb,
                                           input logic [1:0] mode, input logic sgn);
        logic [127:0] v;
        logic [127:0] lo_mask;
        logic [127:0] half;
        logic [127:0] lsbv;
        logic [128:0] sum;
        logic inexact;
        logic rest;
        logic up;
        logic gone;
        v = {m, 64'h0} >> sh;
        lsbv = 128'h1 << (7'h40 + {1'b0, lsb});
        half = lsbv >> 1;
        lo_mask = lsbv - 128'h1;
        inexact = (|(v & lo_mask)) | stk;
        rest = (|(v & lo_mask & ~half)) | stk;
        gone = ~|(v & ~lo_mask);
        case (mode)
            fudh_pkg::RND_NEAREST: up = (|(v & half)) & (rest | (|(v & lsbv)));
            fudh_pkg::RND_TOWARD_MINUS: up = sgn & inexact;
            fudh_pkg::RND_TOWARD_PLUS: up = ~sgn & inexact;
            default: up = 1'b0;
        endcase
        sum = {1'b0, v & ~lo_mask} + ({1'b0, lsbv} & {129{up}});
        return {gone, inexact, sum[128:64]};
    endfunction

    fudh_pkg::fudh_state_t state_q;
    fudh_pkg::fudh_state_t state_d;
    logic op_ready_q;
    logic res_valid_q;
    logic res_write_q;
    logic res_sign_q;
    logic [14:0] res_exp_q;
    logic [63:0] res_mant_q;
    logic mem_trap_q;
    logic trap_tiny_q;
    logic trap_dz_q;
    logic acc_tiny_q;
    logic acc_dz_q;
    logic [ADDR_W-1:0] fault_addr_q;
    logic take_mid_q;
    logic resp_valid_q;
    logic [1:0] resp_prim_q;
    logic frame_valid_q;
    logic eo_sign_q;
    logic [14:0] eo_exp_q;
    logic [63:0] eo_mant_q;

    // Operation decode.
    wire op_fire = op_valid & op_ready_q;
    wire is_div = (op_code == fudh_pkg::OP_FULL_DIV) | (op_code == fudh_pkg::OP_SGL_DIV);
    wire is_sgl_mant = (op_code == fudh_pkg::OP_SGL_DIV) | (op_code == fudh_pkg::OP_SGL_MUL);
    wire is_log = (op_code == fudh_pkg::OP_LOG_TEN) | (op_code == fudh_pkg::OP_LOG_TWO) |
                  (op_code == fudh_pkg::OP_LOG_NAT);
    wire is_log1p = op_code == fudh_pkg::OP_LOG_ONE_PLUS;
    wire is_atanh = op_code == fudh_pkg::OP_ATANH;
    wire is_expo = op_code == fudh_pkg::OP_EXPONENTIAL;

    // Zero-divide detection per operation class.
    wire dz_det = (is_div & src_is_zero & ~dvd_special) | (is_log & src_is_zero) | // [RQ16]
                  (is_log1p & src_is_one & src_sign) | (is_atanh & src_is_one);

    // Single-mantissa operations to a register keep the extended range, so only the mantissa narrows.
    wire ext_range = (rnd_prec == fudh_pkg::PREC_EXT) | (is_sgl_mant & dest_is_reg); // [RQ2]
    wire [17:0] emin = ext_range ? fudh_pkg::EMIN_EXT : // [RQ1]
                       (rnd_prec == fudh_pkg::PREC_DBL) ? fudh_pkg::EMIN_DBL :
                       fudh_pkg::EMIN_SGL;
    wire [5:0] lsb = (is_sgl_mant & dest_is_reg) ? fudh_pkg::LSB_SGL :
                     (rnd_prec == fudh_pkg::PREC_DBL) ? fudh_pkg::LSB_DBL :
                     (rnd_prec == fudh_pkg::PREC_SGL) ? fudh_pkg::LSB_SGL :
                     fudh_pkg::LSB_EXT;
    wire [17:0] exp_s = {int_exp[16], int_exp};

    // Tininess is decided before rounding; the extended minimum itself is normal.
    wire tiny = ~dz_det & (ext_range ? ($signed(exp_s) < $signed(emin)) : // [RQ21] [RQ6]
                                       ($signed(exp_s) <= $signed(emin)));
    wire [17:0] sh_full = emin - exp_s;
    wire [6:0] sh = ~tiny ? 7'h00 : // [RQ4]
                    ($signed(sh_full) > $signed(fudh_pkg::SHIFT_MAX)) ? 7'h7f : sh_full[6:0];

    // Denormalize and round the delivered result.
    wire [66:0] den = rnd_fn(int_mant, int_sticky, sh, lsb, rnd_mode, int_sign); // [RQ3] [RQ4]
    wire den_gone = tiny & den[66];
    wire inexact = den[65];
    wire [17:0] base_exp = tiny ? emin : exp_s;
    wire [17:0] fin_exp = base_exp + {17'h0, den[64]};
    wire [63:0] fin_mant = den[64] ? {1'b1, 63'h0} : den[63:0];
    wire [17:0] fin_bexp = fin_exp + fudh_pkg::BIAS_EXT;
    wire [63:0] small_mant = 64'h1 << lsb;
    wire [14:0] emin_bexp = 15'(emin + fudh_pkg::BIAS_EXT);

    // Everything shifted out: only the directed modes ever yield a nonzero value.
    wire gone_small = (rnd_mode == fudh_pkg::RND_TOWARD_MINUS) ? int_sign : // [RQ5]
                      (rnd_mode == fudh_pkg::RND_TOWARD_PLUS) ? ~int_sign : 1'b0;
    wire [63:0] uf_mant = den_gone ? (gone_small ? small_mant : 64'h0) : fin_mant;
    wire [14:0] uf_exp = (uf_mant == 64'h0) ? fudh_pkg::EXP_ZERO :
                         den_gone ? emin_bexp : fin_bexp[14:0];

    // Divide-by-zero default infinities.
    wire dz_sign = is_div ? (src_sign ^ dvd_sign) : // [RQ18]
                   is_atanh ? ~src_sign : 1'b1;
    wire dz_trap = dz_det & dz_trap_en;
    wire uf_trap = tiny & tiny_result_flag_trap_en;

    // Exceptional operand for an underflow, rounded without denormalizing.
    wire [5:0] eo_lsb = dest_is_reg ? fudh_pkg::LSB_EXT : lsb; // [RQ11] [RQ12]
    wire [66:0] eor = rnd_fn(int_mant, int_sticky, 7'h00, eo_lsb, rnd_mode, int_sign);
    wire [17:0] eo_uexp = exp_s + {17'h0, eor[64]};
    wire [63:0] eo_umant = eor[64] ? {1'b1, 63'h0} : eor[63:0];
    wire [17:0] eo_wrap = eo_uexp + fudh_pkg::BIAS_EXT + fudh_pkg::BIAS_WRAP; // [RQ12]
    wire [17:0] eo_norm = eo_uexp + fudh_pkg::BIAS_EXT; // [RQ11]
    wire cata = is_expo & ($signed(exp_s) <= $signed(fudh_pkg::CATA_LIMIT)); // [RQ13]
    wire [14:0] eo_uf_exp = (dest_is_reg & cata) ? fudh_pkg::EXP_ZERO :
                            dest_is_reg ? eo_wrap[14:0] : eo_norm[14:0];

    // Pending-exception sequencing; a pending trap blocks new operations.
    always_comb begin
        state_d = state_q;
        case (state_q)
            fudh_pkg::ST_IDLE: begin
                if (op_fire && dest_is_reg && (uf_trap || dz_trap)) begin
                    state_d = fudh_pkg::ST_PEND; // [RQ8] [RQ19]
                end
            end
            fudh_pkg::ST_PEND: begin
                if (resp_read || frame_save) begin
                    state_d = fudh_pkg::ST_IDLE; // [RQ22]
                end
            end
            default: state_d = fudh_pkg::ST_IDLE;
        endcase
    end

    // State and handshake registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= fudh_pkg::ST_IDLE;
            op_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_ready_q <= state_d == fudh_pkg::ST_IDLE; // [RQ22]
        end
    end

    // Result write-back; a trapped zero divide leaves the destination alone.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            res_valid_q <= 1'b0;
            res_write_q <= 1'b0;
            res_sign_q <= 1'b0;
            res_exp_q <= fudh_pkg::EXP_ZERO;
            res_mant_q <= 64'h0;
            mem_trap_q <= 1'b0;
        end else begin
            res_valid_q <= op_fire;
            mem_trap_q <= op_fire & ~dest_is_reg & uf_trap; // [RQ7]
            if (op_fire) begin
                res_write_q <= ~dz_trap; // [RQ19]
                res_sign_q <= dz_det ? dz_sign : int_sign;
                res_exp_q <= dz_det ? fudh_pkg::EXP_INF : uf_exp; // [RQ18]
                res_mant_q <= dz_det ? 64'h0 : uf_mant;
            end
        end
    end

    // Trap-cause and sticky flags; a new event wins over a sticky clear.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trap_tiny_q <= 1'b0;
            trap_dz_q <= 1'b0;
            acc_tiny_q <= 1'b0;
            acc_dz_q <= 1'b0;
        end else begin
            if (op_fire) begin
                trap_tiny_q <= tiny; // [RQ15]
                trap_dz_q <= dz_det; // [RQ17]
            end
            acc_tiny_q <= (acc_tiny_q & ~sticky_clear) | (op_fire & tiny & inexact); // [RQ14]
            acc_dz_q <= (acc_dz_q & ~sticky_clear) | (op_fire & dz_det); // [RQ17]
        end
    end

    // Faulting address and exceptional operand, held while an exception waits.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_addr_q <= ADDR_W'(fudh_pkg::ADDR_RST);
            eo_sign_q <= 1'b0;
            eo_exp_q <= fudh_pkg::EXP_ZERO;
            eo_mant_q <= 64'h0;
        end else if (op_fire && (tiny || dz_det)) begin
            fault_addr_q <= op_addr; // [RQ10] [RQ20]
            eo_sign_q <= dz_det ? src_sign : int_sign;
            eo_exp_q <= dz_det ? src_exp : eo_uf_exp; // [RQ20]
            eo_mant_q <= dz_det ? src_mant : eo_umant;
        end
    end

    // Host answers: mid-instruction take follows the stored operand by one cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            take_mid_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_prim_q <= fudh_pkg::PRIM_NONE;
            frame_valid_q <= 1'b0;
        end else begin
            take_mid_q <= mem_trap_q; // [RQ7]
            resp_valid_q <= resp_read;
            frame_valid_q <= frame_save; // [RQ10]
            if (resp_read) begin
                resp_prim_q <= (state_q != fudh_pkg::ST_PEND) ? fudh_pkg::PRIM_NONE : // [RQ8]
                               CONCURRENT ? fudh_pkg::PRIM_MID : fudh_pkg::PRIM_PRE; // [RQ9]
            end
        end
    end

    // Outputs come straight from the registers above.
    assign op_ready = op_ready_q;
    assign res_valid = res_valid_q;
    assign res_write = res_write_q;
    assign res_sign = res_sign_q;
    assign res_exp = res_exp_q;
    assign res_mant = res_mant_q;
    assign trap_tiny_result_flag = trap_tiny_q;
    assign trap_zero_divide_flag = trap_dz_q;
    assign sticky_tiny_result_flag = acc_tiny_q;
    assign sticky_zero_divide_flag = acc_dz_q;
    assign faulting_instruction_address = fault_addr_q;
    assign take_mid = take_mid_q;
    assign resp_valid = resp_valid_q;
    assign resp_prim = resp_prim_q;
    assign frame_valid = frame_valid_q;
    assign eo_sign = eo_sign_q;
    assign eo_exp = eo_exp_q;
    assign eo_mant = eo_mant_q;

    // Checks on the behaviour above.
    chk_dz_flags: // [RQ17]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && dz_det |=> trap_dz_q && acc_dz_q)
        else $error("zero divide did not set both flags");

    chk_dz_keep_dest: // [RQ19]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && dz_det && dz_trap_en && dest_is_reg |=> res_valid_q && !res_write_q
        ##0 state_q == fudh_pkg::ST_PEND)
        else $error("trapped zero divide wrote the destination");

    chk_tiny_cause: // [RQ15]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && tiny && !int_sticky && int_mant[0] == 1'b0 |=> trap_tiny_q)
        else $error("tiny result did not set the trap cause flag");

    chk_sticky_exact: // [RQ14]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && !acc_tiny_q && !(tiny && inexact) |=> !acc_tiny_q)
        else $error("sticky tiny flag set without accuracy loss");

    chk_ext_min: // [RQ6]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && rnd_prec == fudh_pkg::PREC_EXT && exp_s == fudh_pkg::EMIN_EXT
        |=> !trap_tiny_q)
        else $error("extended minimum exponent flagged as tiny");

    chk_mid_order: // [RQ7]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && uf_trap && !dest_is_reg |=> res_valid_q && !take_mid_q ##1 take_mid_q)
        else $error("mid-instruction take not one cycle after the store");

    chk_resp_take: // [RQ8]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == fudh_pkg::ST_PEND && resp_read
        |=> resp_valid_q && resp_prim_q != fudh_pkg::PRIM_NONE && op_ready_q)
        else $error("pending exception not returned on response read");

    chk_hold_operand: // [RQ22]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == fudh_pkg::ST_PEND && !resp_read && !frame_save
        |=> $stable(eo_exp_q) && $stable(fault_addr_q) && $stable(trap_tiny_q))
        else $error("exception state changed while pending");

    chk_cata_zero: // [RQ13]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && tiny && dest_is_reg && cata |=> eo_exp_q == fudh_pkg::EXP_ZERO)
        else $error("catastrophic underflow exponent not zero");

    chk_log_inf: // [RQ18]
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_fire && is_log && src_is_zero |=> res_exp_q == fudh_pkg::EXP_INF && res_sign_q
        && res_mant_q == 64'h0)
        else $error("log of zero did not give minus infinity");

endmodule

// ---- tb/fudh_host_model.sv ----
// Host processor model that reads the response register or saves the state frame on request.
`timescale 1ns/10ps
module fudh_host_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rd_req,
    input wire logic sv_req,
    input wire logic [3:0] lag,
    output logic resp_read,
    output logic frame_save
);
    logic [4:0] cnt_q;
    logic kind_q;

    // A request waits lag plus one cycles, so both a prompt and a slow host are seen by the unit.
    always @(negedge clk_sys) begin
        resp_read <= rst_n && (cnt_q == 5'h01) && !kind_q;
        frame_save <= rst_n && (cnt_q == 5'h01) && kind_q;
        if (!rst_n) begin
            cnt_q <= 5'h00;
        end else if (cnt_q == 5'h01) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else if (rd_req || sv_req) begin
            cnt_q <= {1'b0, lag} + 5'h01;
            kind_q <= sv_req;
        end
    end
endmodule

// ---- tb/test_fp_underflow_divzero_handler.sv ----
// Self-checking bench for the underflow and divide-by-zero exception unit.
`timescale 1ns/10ps
module test_fp_underflow_divzero_handler;
    logic clk_sys, rst_n, op_valid, dest_is_reg, int_sign, int_sticky, src_sign, src_is_zero;
    logic src_is_one, dvd_sign, dvd_special, tiny_result_flag_trap_en, dz_trap_en, sticky_clear, rd_req;
    logic sv_req, resp_read, frame_save, op_ready, res_valid, res_write, res_sign, take_mid;
    logic trap_tiny_result_flag, trap_zero_divide_flag, sticky_tiny_result_flag, resp_valid;
    logic sticky_zero_divide_flag, frame_valid, eo_sign, e_w, e_s, e_os;
    logic [3:0] op_code, lag, e_fl;
    logic [1:0] rnd_prec, rnd_mode, resp_prim;
    logic [16:0] int_exp, emin;
    logic [14:0] src_exp, res_exp, eo_exp, e_e, e_oe;
    logic [63:0] int_mant, src_mant, res_mant, eo_mant, e_m, e_om;
    logic [31:0] op_addr, faulting_instruction_address;
    logic [196:0] exp_q[$], msk_q[$], mon_m;
    int error_cnt, compares, cyc;

    assign emin = fudh_pkg::EMIN_EXT[16:0];

    fudh_unit #(.ADDR_W(32), .CONCURRENT(1'b1)) u_dut (
        .clk_sys, .rst_n, .op_valid, .op_code, .dest_is_reg, .rnd_prec, .rnd_mode, .int_sign,
        .int_exp, .int_mant, .int_sticky, .src_sign, .src_exp, .src_mant, .src_is_zero,
        .src_is_one, .dvd_sign, .dvd_special, .tiny_result_flag_trap_en, .dz_trap_en, .op_addr, .resp_read,
        .frame_save, .sticky_clear, .op_ready, .res_valid, .res_write, .res_sign, .res_exp,
        .res_mant, .trap_tiny_result_flag, .trap_zero_divide_flag, .sticky_tiny_result_flag,
        .sticky_zero_divide_flag, .faulting_instruction_address, .take_mid, .resp_valid,
        .resp_prim, .frame_valid, .eo_sign, .eo_exp, .eo_mant);
    fudh_host_model u_host (.clk_sys, .rst_n, .rd_req, .sv_req, .lag, .resp_read, .frame_save);

    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [196:0] want, input logic [196:0] got);
        compares++;
        if (got !== want) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, want, got);
        end
    endtask

    // Offers one operation and notes the expected result; g picks the field groups compared.
    task automatic go(input logic [6:0] g);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (op_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        op_addr = $urandom;
        op_valid = 1'b1;
        sticky_clear = 1'b1;
        exp_q.push_back({e_w, e_s, e_e, e_m, e_fl, op_addr, e_os, e_oe, e_om});
        msk_q.push_back({g[0], g[1], {15{g[4]}}, {64{g[1]}}, {4{g[2]}}, {32{g[3]}}, g[5],
            {15{g[6]}}, {64{g[5]}}});
        @(negedge clk_sys);
        op_valid = 1'b0;
        sticky_clear = 1'b0;
    endtask

    // Asks the host model for a response read or a frame save and checks the answer.
    task automatic host(input logic save, input logic [3:0] l, input logic [1:0] prim);
        int n;
        n = 0;
        lag <= l;
        if (save) sv_req <= 1'b1;
        else rd_req <= 1'b1;
        @(negedge clk_sys);
        rd_req <= 1'b0;
        sv_req <= 1'b0;
        while ((save ? frame_valid : resp_valid) !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk("answer", 197'h1, {196'h0, save ? frame_valid : resp_valid});
        if (!save) chk("resp_prim", {195'h0, prim}, {195'h0, resp_prim});
        if (save) chk("eo_exp", {182'h0, e_oe}, {182'h0, eo_exp});
        chk("op_ready", 197'h1, {196'h0, op_ready});
    endtask

    // Results arrive in order, so each one is matched against the oldest note.
    // Sampling on the falling edge keeps the check clear of the launching edge.
    always @(negedge clk_sys) begin
        if (rst_n === 1'b1 && res_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("res_valid", 197'h0, 197'h1);
            end else begin
                mon_m = msk_q.pop_front();
                chk("result", exp_q.pop_front() & mon_m, {res_write, res_sign, res_exp, res_mant,
                    trap_tiny_result_flag, trap_zero_divide_flag, sticky_tiny_result_flag,
                    sticky_zero_divide_flag, faulting_instruction_address, eo_sign, eo_exp,
                    eo_mant} & mon_m);
            end
        end
    end

    // Clock generator; starting high puts the first driving edge before the first sample.
    initial begin
        clk_sys = 1'b1;
        forever #5 clk_sys = ~clk_sys;
    end

    // Cuts a hang short well beyond the roughly 100 cycles the sequence needs.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    // Main sequence.
    initial begin
        {rst_n, op_valid, int_sign, int_sticky, src_sign, src_is_zero, src_is_one} = '0;
        {dvd_sign, dvd_special, tiny_result_flag_trap_en, dz_trap_en, sticky_clear, rd_req, sv_req} = '0;
        {op_code, lag, rnd_prec, rnd_mode, int_exp, src_exp, src_mant, op_addr} = '0;
        {error_cnt, compares, cyc} = '0;
        dest_is_reg = 1'b1;
        int_mant = 64'h8000_0000_0000_0000;
        void'($urandom(19533));
        repeat (4) @(negedge clk_sys);
        chk("op_ready", 197'h0, {196'h0, op_ready});
        rst_n = 1'b1;
        e_w = 1'b1;
        e_e = fudh_pkg::EXP_INF;
        e_m = 64'h0;
        e_fl = 4'b0101;
        for (int k = 0; k < 8; k++) begin
            op_code = 4'((k < 2) ? k + 1 : (k < 6) ? k + 2 : 8);
            dvd_sign = 1'($urandom);
            src_sign = (k == 5) ? 1'b1 : (k > 5) ? k[0] : 1'($urandom);
            src_is_zero = (k < 5);
            src_is_one = (k >= 5);
            src_exp = src_is_one ? 15'h3fff : 15'h0000;
            src_mant = src_is_one ? 64'h8000_0000_0000_0000 : 64'h0;
            e_s = (k < 2) ? dvd_sign ^ src_sign : (k < 6) ? 1'b1 : ~src_sign;
            {e_os, e_oe, e_om} = {src_sign, src_exp, src_mant};
            go(7'h7f);
        end
        op_code = 4'h1;
        {src_is_zero, src_is_one, dvd_special, src_exp, src_mant} = {3'b101, 79'h0};
        e_fl = 4'b0000;
        go(7'h04);
        {dvd_special, dz_trap_en, src_sign} = 3'b011;
        {e_w, e_fl, e_os, e_oe, e_om} = {5'b00101, 1'b1, 79'h0};
        go(7'h6d);
        @(negedge clk_sys);
        chk("op_ready", 197'h0, {196'h0, op_ready});
        src_sign = 1'b0;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        chk("eo_sign", 197'h1, {196'h0, eo_sign});
        host(1'b0, 4'h3, 2'h2);
        {dz_trap_en, src_is_zero, op_code, int_exp} = {6'h00, emin - 17'h1};
        {e_w, e_s, e_e, e_m, e_fl} = {2'b10, 15'h0, 64'h4000_0000_0000_0000, 4'b1000};
        go(7'h17);
        int_mant = 64'h8000_0000_0000_0001;
        e_fl = 4'b1010;
        go(7'h17);
        {int_exp, int_mant, e_m, e_fl} = {emin, {2{64'h8000_0000_0000_0000}}, 4'b0000};
        go(7'h17);
        int_exp = emin - 17'h100;
        e_fl = 4'b1010;
        for (int k = 0; k < 8; k++) begin
            {int_sign, rnd_mode} = 3'(k);
            e_s = k[2];
            e_m = (k == 6 || k == 3) ? 64'h1 : 64'h0;
            go(7'h17);
        end
        {rnd_mode, int_sign, int_sticky} = 4'b0001;
        for (int j = 0; j < 5; j++) begin
            op_code = (j == 1) ? 4'h3 : (j == 2) ? 4'h2 : 4'h0;
            rnd_prec = (j < 3) ? fudh_pkg::PREC_SGL : fudh_pkg::PREC_DBL;
            int_exp = ((j < 3) ? fudh_pkg::EMIN_SGL[16:0] : fudh_pkg::EMIN_DBL[16:0]) + 17'(j / 4);
            e_fl = (j == 0 || j == 3) ? 4'b1010 : 4'b0000;
            go(7'h04);
        end
        {op_code, rnd_prec, int_sticky, tiny_result_flag_trap_en, dest_is_reg, int_sign} = 10'h005;
        {int_exp, e_fl, e_os, e_om} = {emin - 17'h1, 4'b1000, 1'b1, 64'h8000_0000_0000_0000};
        go(7'h2c);
        @(negedge clk_sys);
        chk("take_mid", 197'h1, {196'h0, take_mid});
        chk("op_ready", 197'h1, {196'h0, op_ready});
        {dest_is_reg, int_sign, int_exp, e_os, e_oe} = {2'b10, 17'h1c000, 1'b0, 15'h5fff};
        go(7'h6c);
        host(1'b0, 4'h0, 2'h2);
        {op_code, int_exp, e_oe, e_fl} = {4'h9, 17'h16001, 15'h0000, 4'b1010};
        go(7'h6c);
        host(1'b1, 4'h5, 2'h0);
        {int_exp, e_oe} = {17'h16002, 15'h0001};
        go(7'h6c);
        host(1'b0, 4'h1, 2'h2);
        host(1'b0, 4'h2, 2'h0);
        repeat (3) @(negedge clk_sys);
        stop_test();
    end
endmodule
